// ===== sps_pkg.sv
package sps_pkg;
    localparam int PL_BITS = 8;
    localparam int MS_BITS = 2;
    localparam int NOBJ = 4;
    localparam int AW = 8;
    // width state values
    localparam logic [1:0] WST_ZERO = 2'h0;
    localparam logic [1:0] WST_ONE = 2'h1;
    // visible window for collisions
    localparam logic [7:0] HVIS_FIRST = 8'h22;
    localparam logic [7:0] HVIS_LAST = 8'hDD;
    localparam logic [8:0] VVIS_FIRST = 9'h008;
    localparam logic [8:0] VVIS_LAST = 9'h0F7;
    // enhanced colour mode codes
    localparam logic [1:0] CMODE_NORMAL = 2'h0;
    localparam logic [1:0] CMODE_LUMA = 2'h1;
    localparam logic [1:0] CMODE_INDEX = 2'h2;
    localparam logic [1:0] CMODE_HUE = 2'h3;
    // playfield colour index treated as set hi-res bits
    localparam int PF_HIRES_IDX = 2;
    // register word indices (byte address = index * 4)
    localparam logic [5:0] IDX_POS_P = 6'h00;
    localparam logic [5:0] IDX_POS_M = 6'h04;
    localparam logic [5:0] IDX_GFX_P = 6'h08;
    localparam logic [5:0] IDX_GFX_M = 6'h0C;
    localparam logic [5:0] IDX_WID_P = 6'h0D;
    localparam logic [5:0] IDX_WID_M = 6'h11;
    localparam logic [5:0] IDX_CLEAR = 6'h12;
    localparam logic [5:0] IDX_PPF = 6'h14;
    localparam logic [5:0] IDX_MPF = 6'h18;
    localparam logic [5:0] IDX_PPL = 6'h1C;
    localparam logic [5:0] IDX_MPL = 6'h20;
    // words in one group of per-object registers
    localparam logic [5:0] GROUP_WORDS = 6'h04;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== sps_shifter.sv
`timescale 1ns/10ps
module sps_shifter #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic match,
    input wire logic [1:0] size,
    input wire logic [W-1:0] gfx,
    output logic active
);
    import sps_pkg::*;

    typedef struct packed {
        logic [W-1:0] shreg;
        logic [1:0] wstate;
    } sps_shift_t;

    sps_shift_t st_ff;
    sps_shift_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (match) begin
            nxt_st.shreg = st_ff.shreg | gfx;
            nxt_st.wstate = WST_ZERO;
        end else begin
            // size read live, state kept: size changes act at once
            nxt_st.wstate = (st_ff.wstate + WST_ONE) & size;
            if (nxt_st.wstate == WST_ZERO) begin
                nxt_st.shreg = {st_ff.shreg[W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // runs through blanking as well, so a lockup carries over
    assign active = st_ff.shreg[W-1];
endmodule // sps_shifter

// ===== sps_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module sps_top (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [sps_pkg::AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [sps_pkg::AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] hpos_count,
    input wire logic [8:0] scan_line,
    input wire logic vblank_active,
    input wire logic playfield_enable,
    input wire logic [3:0] pf_colour_active,
    input wire logic pf_object_code,
    input wire logic hires_mode,
    input wire logic [1:0] hires_pair,
    input wire logic [1:0] colour_mode,
    input wire logic [3:0] dma_player_load,
    input wire logic [3:0][7:0] dma_player_data,
    input wire logic dma_missile_load,
    input wire logic [7:0] dma_missile_data,
    output logic [3:0] player_active,
    output logic [3:0] missile_active
);
    import sps_pkg::*;

    typedef struct packed {
        logic aw_held;
        logic [AW-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0][7:0] pos_p;
        logic [3:0][7:0] pos_m;
        logic [3:0][7:0] gfx_p;
        logic [7:0] gfx_m;
        logic [3:0][1:0] player_width_code;
        logic [7:0] missile_width_codes;
        logic [3:0][3:0] player_vs_playfield_hits;
        logic [3:0][3:0] missile_vs_playfield_hits;
        logic [3:0][3:0] player_vs_player_hits;
        logic [3:0][3:0] missile_vs_player_hits;
    } sps_state_t;

    sps_state_t st_ff;
    sps_state_t nxt_st;
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    function automatic logic in_range(input logic [5:0] idx, input logic [5:0] base);
        in_range = (idx >= base) && (idx < base + GROUP_WORDS);
    endfunction

    function automatic logic [31:0] pad4(input logic [3:0] v);
        pad4 = {28'h0, v};
    endfunction

    function automatic logic [31:0] pad8(input logic [7:0] v);
        pad8 = {24'h0, v};
    endfunction

    // word indices that answer OKAY; the hole after the clear strobe and every index past the last hit group do not
    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = 1'b0;
        if (idx <= IDX_CLEAR) begin
            is_mapped = 1'b1;
        end else if (in_range(idx, IDX_PPF) || in_range(idx, IDX_MPF)) begin
            is_mapped = 1'b1;
        end else if (in_range(idx, IDX_PPL) || in_range(idx, IDX_MPL)) begin
            is_mapped = 1'b1;
        end
    endfunction

    // object shifters: match compared every colour clock
    logic [3:0] p_match;
    logic [3:0] m_match;
    logic [3:0][1:0] m_gfx;
    genvar gi;
    generate
        for (gi = 0; gi < NOBJ; gi++) begin : g_obj
            assign p_match[gi] = (st_ff.pos_p[gi] == hpos_count);
            assign m_match[gi] = (st_ff.pos_m[gi] == hpos_count);
            assign m_gfx[gi] = st_ff.gfx_m[2*gi +: 2];
            sps_shifter #(.W(PL_BITS)) u_player (
                .clock(clock),
                .rst_n(rst_n),
                .match(p_match[gi]),
                .size(st_ff.player_width_code[gi]),
                .gfx(st_ff.gfx_p[gi]),
                .active(player_active[gi])
            );
            sps_shifter #(.W(MS_BITS)) u_missile (
                .clock(clock),
                .rst_n(rst_n),
                .match(m_match[gi]),
                .size(st_ff.missile_width_codes[2*gi +: 2]),
                .gfx(m_gfx[gi]),
                .active(missile_active[gi])
            );
        end
    endgenerate

    // collision sources
    logic hvis;
    logic vvis;
    logic extend;
    logic detect;
    logic [3:0] pf_eff;

    always_comb begin
        hvis = (hpos_count >= HVIS_FIRST) && (hpos_count <= HVIS_LAST);
        vvis = (scan_line >= VVIS_FIRST) && (scan_line <= VVIS_LAST);
        // lines outside 8-247 count only if vertical blank never came
        extend = !vblank_active && playfield_enable;
        detect = hvis && (vvis || extend);
        pf_eff = pf_colour_active;
        if (colour_mode == CMODE_LUMA || colour_mode == CMODE_HUE) begin
            pf_eff = 4'h0;
        end else if (colour_mode == CMODE_INDEX) begin
            pf_eff = pf_object_code ? 4'h0 : pf_colour_active;
        end else if (hires_mode) begin
            pf_eff = 4'h0;
            pf_eff[PF_HIRES_IDX] = |hires_pair;
        end
    end

    // this cycle's hits, kept apart from the latches so a clear cannot hide them
    logic [3:0][3:0] ppf_now;
    logic [3:0][3:0] mpf_now;
    logic [3:0][3:0] ppl_now;
    logic [3:0][3:0] mpl_now;

    always_comb begin
        ppf_now = '0;
        mpf_now = '0;
        ppl_now = '0;
        mpl_now = '0;
        // sampled from the same flops that feed the display
        if (detect) begin
            for (int i = 0; i < NOBJ; i++) begin
                for (int j = 0; j < NOBJ; j++) begin
                    // colours never enter: only activity is compared
                    ppf_now[i][j] = player_active[i] && pf_eff[j];
                    mpf_now[i][j] = missile_active[i] && pf_eff[j];
                    // each ordered pair on its own, so a third object hides none
                    ppl_now[i][j] = (i != j) && player_active[i] && player_active[j];
                    mpl_now[i][j] = missile_active[i] && player_active[j];
                    // missile pairs have no latch at all
                end
            end
        end
    end

    logic [5:0] widx;
    logic [5:0] ridx;
    logic [1:0] wsel;
    logic [1:0] rsel;
    logic [1:0] wsel_wid;
    logic [1:0] rsel_wid;
    logic do_write;
    logic wr_clear;

    always_comb begin
        nxt_st = st_ff;
        widx = st_ff.awaddr[AW-1:2];
        ridx = s_axi_araddr[AW-1:2];
        wsel = widx[1:0];
        rsel = ridx[1:0];
        // width registers start mid-group, so their lane comes from an offset
        wsel_wid = 2'(widx - IDX_WID_P);
        rsel_wid = 2'(ridx - IDX_WID_P);
        do_write = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
        wr_clear = do_write && (widx == IDX_CLEAR);

        // dma feed of graphics bytes
        for (int i = 0; i < NOBJ; i++) begin
            if (dma_player_load[i]) begin
                nxt_st.gfx_p[i] = dma_player_data[i];
            end
        end
        if (dma_missile_load) begin
            nxt_st.gfx_m = dma_missile_data;
        end

        // axi write: address and data taken in either order
        if (s_axi_awvalid && !st_ff.aw_held) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_held) begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
        end

        // clear first, then this cycle's hits, so a hit is never lost
        if (wr_clear) begin
            nxt_st.player_vs_playfield_hits = '0;
            nxt_st.missile_vs_playfield_hits = '0;
            nxt_st.player_vs_player_hits = '0;
            nxt_st.missile_vs_player_hits = '0;
        end
        if (do_write) begin
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = RESP_OKAY;
            // only byte lane 0 carries data; byte writes elsewhere ignored
            if (st_ff.wstrb[0]) begin
                if (in_range(widx, IDX_POS_P)) begin
                    nxt_st.pos_p[wsel] = st_ff.wdata[7:0];
                end else if (in_range(widx, IDX_POS_M)) begin
                    nxt_st.pos_m[wsel] = st_ff.wdata[7:0];
                end else if (in_range(widx, IDX_GFX_P)) begin
                    nxt_st.gfx_p[wsel] = st_ff.wdata[7:0];
                end else if (widx == IDX_GFX_M) begin
                    nxt_st.gfx_m = st_ff.wdata[7:0];
                end else if (in_range(widx, IDX_WID_P)) begin
                    nxt_st.player_width_code[wsel_wid] = st_ff.wdata[1:0];
                end else if (widx == IDX_WID_M) begin
                    nxt_st.missile_width_codes = st_ff.wdata[7:0];
                end
            end
            if (!is_mapped(widx)) begin
                nxt_st.bresp = RESP_SLVERR;
            end
        end

        // hits merged after the clear, so a hit in the clearing cycle still sets
        nxt_st.player_vs_playfield_hits |= ppf_now;
        nxt_st.missile_vs_playfield_hits |= mpf_now;
        nxt_st.player_vs_player_hits |= ppl_now;
        nxt_st.missile_vs_player_hits |= mpl_now;

        // axi read: one outstanding, answer one cycle after address
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = RESP_OKAY;
            nxt_st.rdata = 32'h0;
            if (in_range(ridx, IDX_POS_P)) begin
                nxt_st.rdata = pad8(st_ff.pos_p[rsel]);
            end else if (in_range(ridx, IDX_POS_M)) begin
                nxt_st.rdata = pad8(st_ff.pos_m[rsel]);
            end else if (in_range(ridx, IDX_GFX_P)) begin
                nxt_st.rdata = pad8(st_ff.gfx_p[rsel]);
            end else if (ridx == IDX_GFX_M) begin
                nxt_st.rdata = pad8(st_ff.gfx_m);
            end else if (in_range(ridx, IDX_WID_P)) begin
                nxt_st.rdata = {30'h0, st_ff.player_width_code[rsel_wid]};
            end else if (ridx == IDX_WID_M) begin
                nxt_st.rdata = pad8(st_ff.missile_width_codes);
            end else if (ridx == IDX_CLEAR) begin
                nxt_st.rdata = 32'h0;
            end else if (in_range(ridx, IDX_PPF)) begin
                nxt_st.rdata = pad4(st_ff.player_vs_playfield_hits[rsel]);
            end else if (in_range(ridx, IDX_MPF)) begin
                nxt_st.rdata = pad4(st_ff.missile_vs_playfield_hits[rsel]);
            end else if (in_range(ridx, IDX_PPL)) begin
                // self bit never set, so it reads zero
                nxt_st.rdata = pad4(st_ff.player_vs_player_hits[rsel]);
            end else if (in_range(ridx, IDX_MPL)) begin
                nxt_st.rdata = pad4(st_ff.missile_vs_player_hits[rsel]);
            end else begin
                nxt_st.rresp = RESP_SLVERR;
            end
        end
    end

    // sixty-four latch bits live in the four hit arrays
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = !st_ff.aw_held;
    assign s_axi_wready = !st_ff.w_held;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
endmodule // sps_top

// ===== sps_chk.sv
`timescale 1ns/10ps
module sps_chk (
    input wire logic clock,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import sps_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wr_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_wr_release: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready)
        else $error("write path not freed");
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read answer late");
    a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_rd_error: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> !s_axi_rdata)
        else $error("error read carries data");
    a_rd_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read answer without request");
endmodule // sps_chk
bind sps_top sps_chk u_chk (.clock, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ===== sps_dma_model.sv
`timescale 1ns/10ps
module sps_dma_model (
    input wire logic clock,
    input wire logic fetch,
    input wire logic [3:0] fetch_mask,
    input wire logic [7:0] fetch_byte,
    output logic [3:0] dma_player_load,
    output logic [3:0][7:0] dma_player_data,
    output logic dma_missile_load,
    output logic [7:0] dma_missile_data
);
    initial begin
        dma_player_load = 4'h0;
        dma_player_data = '0;
        dma_missile_load = 1'h0;
        dma_missile_data = 8'h00;
    end
    // outside a strobe the bytes keep moving, so stale data is never a safe bet
    always @(posedge clock) begin
        dma_player_load <= fetch ? fetch_mask : 4'h0;
        dma_player_data <= fetch ? {4{fetch_byte}} : ~dma_player_data;
        dma_missile_data <= ~dma_missile_data;
    end
endmodule // sps_dma_model

// ===== tb_sprite_shifter_collision.sv
`timescale 1ns/10ps
module tb_sprite_shifter_collision;
    import sps_pkg::*;
    logic clock = 1'h0, rstn = 1'h0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, hpos_count = '0, fetch_byte = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, vblank_active = 0, playfield_enable = 0, pf_object_code = 0;
    logic hires_mode = 0, fetch = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, dma_missile_load;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF, pf_colour_active = '0, fetch_mask = '0;
    logic [3:0] dma_player_load, player_active, missile_active;
    logic [1:0] hires_pair = 2'h1, colour_mode = '0, s_axi_bresp, s_axi_rresp, r;
    logic [8:0] scan_line = '0;
    logic [3:0][7:0] dma_player_data;
    logic [7:0] dma_missile_data;
    logic [31:0] hit_exp [16] = '{2, 2, 2, 0, 2, 2, 0, 0, 6, 5, 3, 0, 7, 7, 0, 0};
    logic [31:0] mode_exp [6] = '{2, 0, 2, 0, 0, 4};
    logic [31:0] wid_exp [4] = '{1, 2, 1, 4};
    int n_fail = 0, n_checks = 0, cnt0, cntm;
    always #25 clock = ~clock;
    sps_top uut (.clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hpos_count, .scan_line, .vblank_active,
        .playfield_enable, .pf_colour_active, .pf_object_code, .hires_mode, .hires_pair,
        .colour_mode, .dma_player_load, .dma_player_data, .dma_missile_load,
        .dma_missile_data, .player_active, .missile_active);
    sps_dma_model u_dma (.clock, .fetch, .fetch_mask, .fetch_byte, .dma_player_load,
        .dma_player_data, .dma_missile_load, .dma_missile_data);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        logic ta, tw;
        n = 0;
        ta = 0;
        tw = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (n < 50 && !(ta && tw && s_axi_bvalid)) begin
            @(posedge clock);
            n++;
            if (!ta && s_axi_awready) begin
                ta = 1;
                s_axi_awvalid <= 0;
            end
            if (!tw && s_axi_wready) begin
                tw = 1;
                s_axi_wvalid <= 0;
            end
        end
        r = s_axi_bresp;
        chk("write done", 1, n < 50);
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        logic ta;
        n = 0;
        ta = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        while (n < 50 && !(ta && s_axi_rvalid)) begin
            @(posedge clock);
            n++;
            if (!ta && s_axi_arready) begin
                ta = 1;
                s_axi_arvalid <= 0;
            end
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        chk("read done", 1, n < 50);
        s_axi_rready <= 0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), e, d);
    endtask
    // one scan line of colour clocks; counts clocks with player 0 lit
    task automatic sweep(input logic [8:0] sl);
        cnt0 = 0;
        cntm = 0;
        scan_line <= sl;
        for (int h = 0; h < 228; h++) begin
            @(posedge clock);
            hpos_count <= h[7:0];
            if (player_active[0] === 1'h1) cnt0++;
            if (missile_active[0] === 1'h1) cntm++;
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        n_fail++;
        $display("MISMATCH run expected end seen timeout");
        conclude();
    end
    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1;
        repeat (3) @(posedge clock);
        chk("player_active", 0, player_active);
        for (int i = 0; i < 16; i++) rc(8'h50 + 8'(4 * i), 0);
        rd(8'hFC);
        chk("unmapped", RESP_SLVERR, r);
        wr(8'h4C, 32'h1);
        chk("unmapped write", RESP_SLVERR, r);
        wr(8'h70, 32'hF);
        chk("hit write resp", RESP_OKAY, r);
        rc(8'h70, 0);
        for (int i = 0; i < 3; i++) wr(8'(4 * i), 8'h40);
        wr(8'h10, 8'h40);
        wr(8'h14, 8'h40);
        wr(8'h30, 8'h0F);
        @(posedge clock);
        fetch <= 1;
        fetch_mask <= 4'h7;
        fetch_byte <= 8'hFF;
        @(posedge clock);
        fetch <= 0;
        pf_colour_active <= 4'h2;
        sweep(9'h014);
        chk("missile lit", 2, 32'(cntm));
        for (int i = 0; i < 16; i++) rc(8'h50 + 8'(4 * i), hit_exp[i]);
        // players pushed into the blank border only
        for (int i = 0; i < 3; i++) wr(8'(4 * i), 8'h10);
        sweep(9'h014);
        rc(8'h70, 6);
        wr(8'h48, 0);
        for (int i = 0; i < 16; i++) rc(8'h50 + 8'(4 * i), 0);
        sweep(9'h014);
        rc(8'h70, 0);
        for (int i = 0; i < 3; i++) wr(8'(4 * i), 8'h40);
        vblank_active <= 1;
        sweep(9'h0FA);
        rc(8'h70, 0);
        vblank_active <= 0;
        playfield_enable <= 1;
        sweep(9'h0FA);
        rc(8'h70, 6);
        playfield_enable <= 0;
        for (int i = 0; i < 6; i++) begin
            wr(8'h48, 0);
            colour_mode <= (i == 5) ? 2'h0 : (i == 4) ? 2'h2 : i[1:0];
            pf_object_code <= (i == 4);
            hires_mode <= (i == 5);
            sweep(9'h014);
            rc(8'h50, mode_exp[i]);
        end
        wr(8'h20, 8'h80);
        for (int w = 0; w < 4; w++) begin
            wr(8'h34, w);
            sweep(9'h014);
            chk("lit clocks", wid_exp[w], 32'(cnt0));
        end
        conclude();
    end
endmodule // tb_sprite_shifter_collision
